// *** bias_startup_consts.svh ***
// Register indices, field positions, reset values and timing constants.
`ifndef BIAS_STARTUP_CONSTS_SVH
`define BIAS_STARTUP_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_RANGE 10'h0b9
`define IDX_HSTEP 10'h0ba
`define IDX_LSTEP 10'h0bb
`define IDX_THRESH 10'h0c5
`define IDX_CEIL 10'h0ee
`define IDX_STATUS 10'h0f0
`define IDX_MASK 10'h0f1
`define IDX_BIAS 10'h0f2

// Field layout of the range register
`define RANGE_BIAS_LSB 4
`define RANGE_POWER_LSB 0
`define RANGE_LIVE_MASK 8'h77

// Reset and factory default values
`define RANGE_RST 8'h00
`define STEP_RST 8'h00
`define THRESH_RST 8'h00
`define CEIL_RST 8'hff
`define MASK_RST 4'h0
`define BIAS_RST 9'h000

// Status bit positions
`define ST_DONE 0
`define ST_CEIL 1
`define ST_LIMIT 2
`define ST_DENIED 3

// Full-scale references in millivolts
`define BIAS_FS_MV 1250
`define POWER_FS_MV 2500

// Settle time after each bias change
`define CLK_PERIOD_NS 8
`define SETTLE_NS 1000
`define SETTLE_CYCLES ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// AXI responses
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define RESP_DECERR 2'b11

`endif

// *** bias_startup_pkg.sv ***
// Types shared by the bias startup and ranging block.
package bias_startup_pkg;

    // Startup sequencer states
    typedef enum logic [1:0] {
        S_HOLD,
        S_STEP,
        S_SEARCH,
        S_RUN
    } state_t;

    // Privilege inputs from the password logic
    typedef struct packed {
        logic upper_password_level;
        logic lower_password_level;
        logic cfg_table_rw_grant;
        logic cfg_table_read_grant;
    } access_t;

    // Range selectors driven to the comparators
    typedef struct packed {
        logic [2:0] bias_range_select;
        logic [2:0] power_loop_range_select;
        logic [11:0] bias_fs_mv;
        logic [11:0] power_fs_mv;
    } range_out_t;

endpackage

// *** range_scale.sv ***
// Full-scale voltage lookup for one 3-bit quick-trip range selector.
`timescale 1ns/1ps
module range_scale #(
    parameter int FS_MV = 1250
) (
    input wire logic [2:0] i_sel,
    output logic [11:0] o_fs_mv
);
    initial
    begin
        if (FS_MV < 1 || FS_MV > 4095)
            $error("range_scale: FS_MV out of range");
    end

    // Fractions 4/4,4/5,4/6,4/8,4/10,4/12,4/14,4/16, rounded to nearest mV
    always_comb
    begin
        case (i_sel)
            3'h0: o_fs_mv = 12'(FS_MV);
            3'h1: o_fs_mv = 12'((FS_MV * 4 + 2) / 5);
            3'h2: o_fs_mv = 12'((FS_MV * 4 + 3) / 6);
            3'h3: o_fs_mv = 12'((FS_MV * 4 + 4) / 8);
            3'h4: o_fs_mv = 12'((FS_MV * 4 + 5) / 10);
            3'h5: o_fs_mv = 12'((FS_MV * 4 + 6) / 12);
            3'h6: o_fs_mv = 12'((FS_MV * 4 + 7) / 14);
            default: o_fs_mv = 12'((FS_MV * 4 + 8) / 16);
        endcase
    end
endmodule

// *** settle_timer.sv ***
// Down counter that pulses once a fixed settle time after each start.
`timescale 1ns/1ps
module settle_timer #(
    parameter int CYCLES = 125
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_start,
    output logic o_done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] count_q;

    initial
    begin
        if (CYCLES < 1)
            $error("settle_timer: CYCLES must be at least one");
    end

    // A new start restarts the wait
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            count_q <= '0;
        else if (i_start)
            count_q <= CW'(CYCLES);
        else if (count_q != '0)
            count_q <= count_q - CW'(1);
    end

    // Not gated by i_start: callers derive the start from done itself
    assign o_done = count_q == CW'(1);
endmodule

// *** bias_startup_step_ranging.sv ***
// Quick-trip ranging, initial bias step registers and bias startup sequencer.
//
// How it works
// - Range register bits 6:4 pick the bias quick-trip full-scale range.
// - Bias range code 0 gives 1.25 V; code 7 gives 25 percent.
// - Range bits 2:0 pick power-loop quick-trip and loop comparison range.
// - Power range code 0 gives 2.50 V; same fraction ladder, code 3 is 1.25 V.
// - Step register holds bits 8 down to 1 of the step value.
// - Step registers keep contents across power cycles.
// - Step writes need upper level, or lower level with rw grant; reads also read grant.
// - Startup runs at power-on and after every transmit-disable pulse.
// - Temperature above threshold picks high step, below picks low step.
// - Startup adds selected step plus one until power feedback exceeds threshold.
// - Then a binary search on the bias value completes loop startup.
// - A sum above the bias ceiling is not loaded; search starts at once.
// - No bias ceiling alarm while startup stepping runs.
// - Ceiling alarm detection enabled only after the search completes.
`timescale 1ns/1ps
`include "bias_startup_consts.svh"
module bias_startup_step_ranging #(
    parameter int SETTLE_CYCLES = `SETTLE_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_nv_init,
    input wire bias_startup_pkg::access_t i_access,
    input wire logic i_tx_disable,
    input wire logic [7:0] i_temperature_index,
    input wire logic i_power_feedback_above,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output bias_startup_pkg::range_out_t o_range,
    output logic [8:0] o_bias_dac,
    output logic o_bias_ceiling_alarm,
    output logic o_startup_busy,
    output logic o_irq
);
    localparam int BIAS_W = 9;

    initial
    begin
        if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535)
            $error("bias_startup_step_ranging: SETTLE_CYCLES out of range");
    end

    // =========================================================
    // Register storage
    // =========================================================
    logic [7:0] range_q;
    logic [7:0] hstep_q;
    logic [7:0] lstep_q;
    logic [7:0] thresh_q;
    logic [7:0] ceil_q;
    logic [3:0] status_q;
    logic [3:0] mask_q;
    bias_startup_pkg::state_t state_q;
    logic [BIAS_W-1:0] bias_q;
    logic [BIAS_W-1:0] result_q;
    logic [BIAS_W-1:0] bit_q;
    logic alarm_q;

    // =========================================================
    // AXI4-Lite write channel
    // =========================================================
    logic aw_held_q;
    logic w_held_q;
    logic [9:0] aw_idx_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic [1:0] wr_resp;
    logic wr_ok;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_fire = aw_held_q && w_held_q && !bvalid_q;

    // Address and data may arrive in either order; each is held until both are in
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_idx_q <= 10'h000;
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_q <= 1'b1;
                aw_idx_q <= s_axi_awaddr[11:2];
            end
            else if (wr_fire)
                aw_held_q <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            else if (wr_fire)
                w_held_q <= 1'b0;
        end
    end

    // Privilege and decode of the held write
    logic step_wr_allowed;
    logic step_rd_allowed;
    assign step_wr_allowed = i_access.upper_password_level
        || (i_access.lower_password_level && i_access.cfg_table_rw_grant);
    assign step_rd_allowed = step_wr_allowed
        || (i_access.lower_password_level && i_access.cfg_table_read_grant);

    always_comb
    begin
        wr_resp = `RESP_OKAY;
        wr_ok = 1'b0;
        case (aw_idx_q)
            `IDX_RANGE:
            begin
                wr_ok = i_access.upper_password_level;
                wr_resp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            `IDX_HSTEP, `IDX_LSTEP, `IDX_THRESH, `IDX_CEIL:
            begin
                wr_ok = step_wr_allowed;
                wr_resp = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end
            `IDX_STATUS, `IDX_MASK, `IDX_BIAS:
                wr_ok = 1'b1;
            default:
                wr_resp = `RESP_DECERR;
        endcase
    end

    logic wr_do;
    logic wr_denied;
    assign wr_do = wr_fire && wr_ok && wstrb0_q;
    assign wr_denied = wr_fire && (wr_resp == `RESP_SLVERR);

    // Write response stands until the master takes it
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            bvalid_q <= 1'b0;
            bresp_q <= `RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_resp;
        end
        else if (s_axi_bready)
            bvalid_q <= 1'b0;
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // =========================================================
    // AXI4-Lite read channel
    // =========================================================
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_fire;
    logic [9:0] rd_idx;
    logic [7:0] rd_val;
    logic [1:0] rd_resp;
    logic rd_status;

    assign s_axi_arready = !rvalid_q;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign rd_idx = s_axi_araddr[11:2];

    always_comb
    begin
        rd_val = 8'h00;
        rd_resp = `RESP_OKAY;
        case (rd_idx)
            `IDX_RANGE:
            begin
                rd_val = i_access.upper_password_level ? range_q : 8'h00;
                rd_resp = i_access.upper_password_level ? `RESP_OKAY : `RESP_SLVERR;
            end
            `IDX_HSTEP, `IDX_LSTEP, `IDX_THRESH, `IDX_CEIL:
            begin
                rd_resp = step_rd_allowed ? `RESP_OKAY : `RESP_SLVERR;
                if (step_rd_allowed)
                begin
                    case (rd_idx)
                        `IDX_HSTEP: rd_val = hstep_q;
                        `IDX_LSTEP: rd_val = lstep_q;
                        `IDX_THRESH: rd_val = thresh_q;
                        default: rd_val = ceil_q;
                    endcase
                end
            end
            `IDX_STATUS: rd_val = {4'h0, status_q};
            `IDX_MASK: rd_val = {4'h0, mask_q};
            `IDX_BIAS: rd_val = bias_q[8:1];
            default: rd_resp = `RESP_DECERR;
        endcase
    end

    assign rd_status = rd_fire && (rd_idx == `IDX_STATUS);

    // Read data is captured so it stands while rvalid waits for rready
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= `RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_q <= 1'b1;
            rdata_q <= {24'h00_0000, rd_val};
            rresp_q <= rd_resp;
        end
        else if (s_axi_rready)
            rvalid_q <= 1'b0;
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // =========================================================
    // Nonvolatile configuration
    // =========================================================
    // Not touched by i_reset so contents survive a power cycle; only factory init reloads defaults
    always_ff @(posedge i_core_clk)
    begin
        if (i_nv_init)
        begin
            range_q <= `RANGE_RST;
            hstep_q <= `STEP_RST;
            lstep_q <= `STEP_RST;
            thresh_q <= `THRESH_RST;
            ceil_q <= `CEIL_RST;
        end
        else if (wr_do)
        begin
            case (aw_idx_q)
                `IDX_RANGE: range_q <= wdata_q & `RANGE_LIVE_MASK;
                `IDX_HSTEP: hstep_q <= wdata_q;
                `IDX_LSTEP: lstep_q <= wdata_q;
                `IDX_THRESH: thresh_q <= wdata_q;
                `IDX_CEIL: ceil_q <= wdata_q;
                default: ;
            endcase
        end
    end

    // Interrupt mask
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            mask_q <= `MASK_RST;
        else if (wr_do && aw_idx_q == `IDX_MASK)
            mask_q <= wdata_q[3:0];
    end

    // =========================================================
    // Range outputs
    // =========================================================
    assign o_range.bias_range_select = range_q[`RANGE_BIAS_LSB +: 3];
    assign o_range.power_loop_range_select = range_q[`RANGE_POWER_LSB +: 3];

    range_scale #(.FS_MV(`BIAS_FS_MV)) u_bias_scale (
        .i_sel(o_range.bias_range_select),
        .o_fs_mv(o_range.bias_fs_mv)
    );

    range_scale #(.FS_MV(`POWER_FS_MV)) u_power_scale (
        .i_sel(o_range.power_loop_range_select),
        .o_fs_mv(o_range.power_fs_mv)
    );

    // =========================================================
    // Startup sequencer
    // =========================================================
    logic [7:0] step_sel;
    logic [BIAS_W:0] step_sum;
    logic [BIAS_W:0] ceiling;
    logic over;
    logic load;
    logic settled;
    logic [BIAS_W-1:0] keep_val;
    logic done_evt;
    logic limit_evt;

    // Ties resolve to the low step
    assign step_sel = (i_temperature_index > thresh_q) ? hstep_q : lstep_q;
    // Stored byte is bits 8:1 of the step; the extra one is the 2^0 term
    assign step_sum = {1'b0, bias_q} + {1'b0, step_sel, 1'b0} + 10'h001;
    assign ceiling = {1'b0, ceil_q, 1'b1};
    assign over = step_sum > ceiling;
    assign keep_val = i_power_feedback_above ? result_q : bias_q;

    settle_timer #(.CYCLES(SETTLE_CYCLES)) u_settle (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_start(load),
        .o_done(settled)
    );

    // Every bias change except the final load on entry to S_RUN restarts the settle wait before feedback is judged
    always_comb
    begin
        load = 1'b0;
        case (state_q)
            bias_startup_pkg::S_HOLD: load = !i_tx_disable;
            bias_startup_pkg::S_STEP: load = settled;
            bias_startup_pkg::S_SEARCH: load = settled && !bit_q[0];
            default: load = 1'b0;
        endcase
    end

    assign done_evt = (state_q == bias_startup_pkg::S_SEARCH) && settled && bit_q[0];
    assign limit_evt = (state_q == bias_startup_pkg::S_STEP) && settled
        && !i_power_feedback_above && over;

    // Transmit disable parks the bias; its release restarts from zero
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset || i_tx_disable)
        begin
            state_q <= bias_startup_pkg::S_HOLD;
            bias_q <= `BIAS_RST;
            result_q <= `BIAS_RST;
            bit_q <= 9'h100;
        end
        else
        begin
            case (state_q)
                bias_startup_pkg::S_HOLD:
                begin
                    state_q <= bias_startup_pkg::S_STEP;
                    bias_q <= `BIAS_RST;
                end
                bias_startup_pkg::S_STEP:
                begin
                    if (settled && (i_power_feedback_above || over))
                    begin
                        // Oversized sum is dropped and the search begins
                        state_q <= bias_startup_pkg::S_SEARCH;
                        result_q <= `BIAS_RST;
                        bit_q <= 9'h100;
                        bias_q <= 9'h100;
                    end
                    else if (settled)
                        bias_q <= step_sum[BIAS_W-1:0];
                end
                bias_startup_pkg::S_SEARCH:
                begin
                    if (settled && bit_q[0])
                    begin
                        state_q <= bias_startup_pkg::S_RUN;
                        bias_q <= keep_val;
                    end
                    else if (settled)
                    begin
                        // Keep the trial bit only if feedback stayed below threshold
                        result_q <= keep_val;
                        bit_q <= bit_q >> 1;
                        bias_q <= keep_val | (bit_q >> 1);
                    end
                end
                default: ;
            endcase
        end
    end

    // Ceiling alarm only watched once startup has finished
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            alarm_q <= 1'b0;
        else
            alarm_q <= (state_q == bias_startup_pkg::S_RUN)
                && ({1'b0, bias_q} > ceiling);
    end

    assign o_bias_dac = bias_q;
    assign o_bias_ceiling_alarm = alarm_q;
    assign o_startup_busy = state_q != bias_startup_pkg::S_RUN;

    // =========================================================
    // Interrupt status
    // =========================================================
    logic [3:0] status_set;
    assign status_set = {wr_denied || (rd_fire && rd_resp == `RESP_SLVERR),
        limit_evt, alarm_q, done_evt};

    // Read clears, but an event in the same cycle still lands
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            status_q <= 4'h0;
        else
            status_q <= (rd_status ? 4'h0 : status_q) | status_set;
    end

    assign o_irq = |(status_q & mask_q);

    // =========================================================
    // Checks
    // =========================================================
    a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (i_reset)
        !i_nv_init |=> (range_q[7] == 1'b0 && range_q[3] == 1'b0))
        else $error("reserved range bits set");

    a_range_guard: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (wr_fire && aw_idx_q == `IDX_RANGE && !i_access.upper_password_level
        && !i_nv_init) |=> range_q == $past(range_q) && bresp_q == `RESP_SLVERR)
        else $error("range write without upper level took effect");

    a_step_guard: assert property (@(posedge i_core_clk) disable iff (i_reset)
        (rd_fire && rd_idx == `IDX_HSTEP && !step_rd_allowed)
        |=> rvalid_q && rdata_q == 32'h0 && rresp_q == `RESP_SLVERR)
        else $error("step read without grant answered");

    a_bias_code7: assert property (@(posedge i_core_clk)
        o_range.bias_range_select == 3'h7 |-> o_range.bias_fs_mv == 12'h139)
        else $error("bias range code 7 not 313 mV");

    a_power_code3: assert property (@(posedge i_core_clk)
        o_range.power_loop_range_select == 3'h3 |-> o_range.power_fs_mv == 12'h4e2)
        else $error("power range code 3 not 1250 mV");

    a_step_add: assert property (@(posedge i_core_clk)
        disable iff (i_reset || i_tx_disable)
        (state_q == bias_startup_pkg::S_STEP && settled && !i_power_feedback_above && !over)
        |=> bias_q == $past(step_sum[BIAS_W-1:0]) && state_q == bias_startup_pkg::S_STEP)
        else $error("bias step not applied");

    a_over_search: assert property (@(posedge i_core_clk)
        disable iff (i_reset || i_tx_disable)
        (state_q == bias_startup_pkg::S_STEP && settled && over)
        |=> state_q == bias_startup_pkg::S_SEARCH && bias_q == 9'h100)
        else $error("oversized sum loaded");

    a_no_early_alarm: assert property (@(posedge i_core_clk) disable iff (i_reset)
        $past(state_q) != bias_startup_pkg::S_RUN |-> !o_bias_ceiling_alarm)
        else $error("ceiling alarm during startup");

    a_startup_restart: assert property (@(posedge i_core_clk)
        disable iff (i_reset)
        $fell(i_tx_disable) |=> state_q == bias_startup_pkg::S_STEP && bias_q == 9'h000)
        else $error("startup not restarted");
endmodule

// *** bias_dac_model.sv ***
// Bias DAC and power feedback comparator as seen from the startup block.
`timescale 1ns/1ps
module bias_dac_model (
    input wire logic i_core_clk,
    input wire logic [8:0] i_bias_dac,
    input wire logic [8:0] i_target,
    output logic o_power_feedback_above
);
    // ==========
    // Optical path: power lags the DAC by one cycle, as a real laser does
    always_ff @(posedge i_core_clk)
    begin
        o_power_feedback_above <= i_bias_dac > i_target;
    end
endmodule

// *** tb_bias_startup_step_ranging.sv ***
// Self-checking bench for the bias startup, step and ranging block.
`timescale 1ns/1ps
`include "bias_startup_consts.svh"
module tb_bias_startup_step_ranging;
    logic i_core_clk, i_reset, i_nv_init, i_tx_disable, i_power_feedback_above;
    bias_startup_pkg::access_t i_access;
    logic [7:0] i_temperature_index, h, l;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, v;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    bias_startup_pkg::range_out_t o_range;
    logic [8:0] o_bias_dac, target;
    logic o_bias_ceiling_alarm, o_startup_busy, o_irq;
    int n_mismatch = 0;
    int n_checks = 0;
    int seed = 32'h4b3e489c;
    // Short settle keeps each startup brief
    bias_startup_step_ranging #(.SETTLE_CYCLES(4)) bias_startup_step_ranging_i (.*);
    bias_dac_model bias_dac_model_i (.i_core_clk(i_core_clk), .i_bias_dac(o_bias_dac),
        .i_target(target), .o_power_feedback_above(i_power_feedback_above));
    initial
    begin
        i_core_clk = 1'b0;
        forever #4 i_core_clk = ~i_core_clk;
    end
    // ==========
    // Helpers
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Full scale in mV: ladder of 2/2, 2/2.5, 2/3 .. 2/8, rounded
    function automatic logic [11:0] fs(input int full, input int c);
        int d;
        d = (c < 2) ? 4 + c : 2 * c + 2;
        return 12'((full * 4 + d / 2) / d);
    endfunction
    // One AXI4-Lite access; readies sampled at the falling edge to dodge races
    task automatic axi(input bit w, input logic [9:0] a, input logic [31:0] d,
        input logic [1:0] e);
        bit aw, wr, ar, fin;
        logic [1:0] r;
        logic [31:0] q;
        fin = 1'b0;
        @(posedge i_core_clk);
        s_axi_awaddr <= {a, 2'b00};
        s_axi_araddr <= {a, 2'b00};
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
        {s_axi_arvalid, s_axi_rready} <= {2{!w}};
        for (int t = 0; t < 40 && !fin; t++)
        begin
            @(negedge i_core_clk);
            {aw, wr, ar} = {s_axi_awready, s_axi_wready, s_axi_arready};
            fin = w ? s_axi_bvalid : s_axi_rvalid;
            r = w ? s_axi_bresp : s_axi_rresp;
            q = s_axi_rdata;
            @(posedge i_core_clk);
            s_axi_awvalid <= s_axi_awvalid && !aw;
            s_axi_wvalid <= s_axi_wvalid && !wr;
            s_axi_arvalid <= s_axi_arvalid && !ar;
        end
        {s_axi_bready, s_axi_rready} <= 2'b00;
        chk({31'h0, fin}, 32'h1);
        chk({30'h0, r}, {30'h0, e});
        if (!w)
            chk(q, d);
    endtask
    // Optional transmit-disable pulse, then follow the ramp and the search
    task automatic start(input bit p, input logic [8:0] e, input logic ea);
        int k;
        if (p)
        begin
            @(posedge i_core_clk);
            i_tx_disable <= 1'b1;
            repeat (3) @(posedge i_core_clk);
            i_tx_disable <= 1'b0;
        end
        for (k = 0; k < 99 && o_bias_dac === 9'h000; k++)
            @(negedge i_core_clk);
        chk({23'h0, o_bias_dac}, {23'h0, e});
        for (k = 0; k < 4000 && o_startup_busy !== 1'b0; k++)
        begin
            @(negedge i_core_clk);
            chk({31'h0, o_bias_ceiling_alarm && o_startup_busy}, 32'h0);
        end
        repeat (2) @(negedge i_core_clk);
        chk({23'h0, o_bias_dac}, {23'h0, target});
        chk({31'h0, o_startup_busy}, 32'h0);
        chk({31'h0, o_bias_ceiling_alarm}, {31'h0, ea});
        $display("Startup test done at %0t", $time);
    endtask
    task automatic summarize();
        $display("Checks %0d, mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // ==========
    // Main sequence
    initial
    begin
        {i_reset, i_nv_init, i_tx_disable} = 3'b110;
        i_access = 4'h8;
        i_temperature_index = 8'h00;
        target = 9'h040;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'hf;
        repeat (4) @(posedge i_core_clk);
        {i_reset, i_nv_init} <= 2'b00;
        start(1'b0, 9'h001, 1'b0);
        axi(0, `IDX_RANGE, 32'h0, `RESP_OKAY);
        axi(0, `IDX_HSTEP, 32'h0, `RESP_OKAY);
        for (int c = 0; c < 8; c++)
        begin
            v = $random(seed);
            v[6:4] = c[2:0];
            v[2:0] = 3'(7 - c);
            axi(1, `IDX_RANGE, v, `RESP_OKAY);
            axi(0, `IDX_RANGE, v & 32'h77, `RESP_OKAY);
            chk(32'(o_range), 32'({v[6:4], v[2:0], fs(`BIAS_FS_MV, c),
                fs(`POWER_FS_MV, 7 - c)}));
        end
        $display("Ranging test done");
        axi(0, `IDX_STATUS, 32'h1, `RESP_OKAY);
        h = 8'($random(seed) & 32'h1f);
        i_access <= 4'h6;
        axi(1, `IDX_RANGE, 32'h11, `RESP_SLVERR);
        axi(0, `IDX_RANGE, 32'h0, `RESP_SLVERR);
        axi(1, `IDX_HSTEP, {24'h0, h}, `RESP_OKAY);
        i_access <= 4'h5;
        axi(0, `IDX_HSTEP, {24'h0, h}, `RESP_OKAY);
        axi(1, `IDX_HSTEP, 32'h0, `RESP_SLVERR);
        i_access <= 4'h4;
        axi(0, `IDX_HSTEP, 32'h0, `RESP_SLVERR);
        i_access <= 4'h8;
        @(negedge i_core_clk);
        chk({31'h0, o_irq}, 32'h0);
        axi(1, `IDX_MASK, 32'h8, `RESP_OKAY);
        @(negedge i_core_clk);
        chk({31'h0, o_irq}, 32'h1);
        axi(0, `IDX_STATUS, 32'h8, `RESP_OKAY);
        @(negedge i_core_clk);
        chk({31'h0, o_irq}, 32'h0);
        axi(0, 10'h001, 32'h0, `RESP_DECERR);
        axi(1, 10'h001, 32'h0, `RESP_DECERR);
        $display("Access test done");
        i_reset <= 1'b1;
        repeat (2) @(posedge i_core_clk);
        i_reset <= 1'b0;
        axi(0, `IDX_HSTEP, {24'h0, h}, `RESP_OKAY);
        // Byte lane 0 strobe low: write answered but nothing stored
        s_axi_wstrb <= 4'he;
        axi(1, `IDX_HSTEP, 32'h55, `RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        axi(0, `IDX_HSTEP, {24'h0, h}, `RESP_OKAY);
        l = 8'($random(seed) & 32'h1f);
        axi(1, `IDX_LSTEP, {24'h0, l}, `RESP_OKAY);
        axi(1, `IDX_THRESH, 32'h40, `RESP_OKAY);
        target <= 9'h080 + 9'($random(seed) & 32'hff);
        i_temperature_index <= 8'h41;
        start(1'b1, 9'({h, 1'b0}) + 9'h001, 1'b0);
        i_temperature_index <= 8'h40;
        start(1'b1, 9'({l, 1'b0}) + 9'h001, 1'b0);
        axi(0, `IDX_STATUS, 32'h1, `RESP_OKAY);
        axi(1, `IDX_CEIL, 32'h20, `RESP_OKAY);
        axi(1, `IDX_HSTEP, 32'h30, `RESP_OKAY);
        target <= 9'h150;
        i_temperature_index <= 8'h41;
        start(1'b1, 9'h100, 1'b1);
        axi(0, `IDX_STATUS, 32'h7, `RESP_OKAY);
        // Readback shows bias bits 8:1 of the settled 0x150
        axi(0, `IDX_BIAS, 32'ha8, `RESP_OKAY);
        summarize();
    end
    // Watchdog, far beyond the expected run
    initial
    begin
        #500000;
        n_mismatch++;
        summarize();
    end
endmodule
